//--- src/wdt_pkg.sv
package wdt_pkg;

	// Time base
	localparam int CLK_PERIOD_NS = 50;
	localparam int SLOW_PERIOD_NS = 1_000_000;
	localparam int SLOW_DIV       = SLOW_PERIOD_NS / CLK_PERIOD_NS;

	// Counter width in bits, and timeout lengths in counting-clock cycles
	localparam int CNT_W     = 18;
	localparam int SLOW_TO_S = 32'h0000_0020;
	localparam int SLOW_TO_M = 32'h0000_0100;
	localparam int SLOW_TO_L = 32'h0000_0400;
	localparam int BUS_TO_S  = 32'h0000_2000;
	localparam int BUS_TO_M  = 32'h0001_0000;
	localparam int BUS_TO_L  = 32'h0004_0000;

	// Service bytes
	localparam logic [7:0] SVC_FIRST  = 8'h55;
	localparam logic [7:0] SVC_SECOND = 8'hAA;

	// Option register field positions
	localparam int TSEL_POS = 6;
	localparam int CLKS_POS = 7;
	localparam int WIN_POS  = 6;

	// Reset values and encodings of the option fields
	localparam logic [1:0] TSEL_RST = 2'h3;
	localparam logic [1:0] TSEL_OFF = 2'h0;
	localparam logic       CLKS_RST = 1'h1;
	localparam logic       WIN_RST  = 1'h0;
	localparam logic       CLKS_BUS = 1'h0;
	localparam logic       CLKS_SLOW = 1'h1;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} wdt_wr_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b01,
		SEQ_ARMED = 2'b10
	} wdt_seq_t;

endpackage

//--- src/wdt_prescale.sv
`timescale 1ns/10ps
module wdt_prescale import wdt_pkg::*; #(
	parameter int DIV = SLOW_DIV
) (
	input  wire logic core_clk, // System clock
	input  wire logic nrst,     // Async reset, active low
	output logic      tick      // One-cycle enable per DIV cycles
);
	if (DIV < 2) begin : g_chk
		$error("wdt_prescale: DIV must be at least 2");
	end

	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic        next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_cnt  = cnt + 32'h0000_0001;
		if (cnt == 32'(DIV - 1)) begin
			next_cnt  = 32'h0000_0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt  <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

//--- src/wdt_top.sv
`timescale 1ns/10ps
// Behaviour
// RQ1 - Watchdog enabled after every reset; only a zero timeout select disables it.
// RQ2 - Writing 0x55 then 0xAA to status address restarts the timeout.
// RQ3 - Service writes never alter the read-only reset status contents.
// RQ4 - Timeout expiry without completed service requests a system reset.
// RQ5 - Any other byte written to the status address resets immediately; code ignores it while the watchdog is disabled.
// RQ6 - Clock select picks bus clock or the 1 kHz low-power tick.
// RQ7 - Three timeouts per source; default 1 kHz source, longest 2^10.
// RQ8 - Bus clock with window enable: service only in last 25 percent.
// RQ9 - In window mode a premature service write resets immediately.
// RQ10 - No window with 1 kHz source; service accepted anytime.
// RQ11 - Counter initialised by reset and first option writes; later writes ignored.
// RQ12 - Bus clock: counter holds in debug or stop, resumes after.
// RQ13 - 1 kHz source: counter cleared in debug or stop, restarts from zero.
// RQ14 - Software should write both option registers during initialisation.
// RQ15 - Software should service from main flow, not from an interrupt.
// RQ16 - All three timeouts per source are parameters; longest 2^10 on 1 kHz.
module wdt_top import wdt_pkg::*; #(
	parameter int SLOW_DIVIDE = SLOW_DIV,
	parameter int SLOW_SHORT  = SLOW_TO_S,
	parameter int SLOW_MID    = SLOW_TO_M,
	parameter int SLOW_LONG   = SLOW_TO_L,
	parameter int BUS_SHORT  = BUS_TO_S,
	parameter int BUS_MID    = BUS_TO_M,
	parameter int BUS_LONG   = BUS_TO_L
) (
	input  wire logic    core_clk,      // 20 MHz bus clock
	input  wire logic    nrst,          // Async reset, active low
	input  wire wdt_wr_t status_wr,     // Write to status register address
	input  wire wdt_wr_t opt_one_wr,    // Write to system options one
	input  wire wdt_wr_t opt_two_wr,    // Write to system options two
	input  wire logic    debug_mode,    // Background debug active
	input  wire logic    stop_mode,     // Stop mode active
	output logic         sys_reset_req, // One-cycle system reset request
	output logic         wdt_caused,    // Sticky: last reset came from watchdog
	output logic         wdt_enabled    // Watchdog currently enabled
);
	if (SLOW_SHORT < 4 || BUS_SHORT < 4 || SLOW_LONG > (1 << CNT_W) || BUS_LONG > (1 << CNT_W)) begin : g_chk
		$error("wdt_top: timeout lengths out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [CNT_W-1:0] cnt;
	logic [1:0]       tsel;
	logic             clks;
	logic             win_en;
	logic             opt_one_lock;
	logic             opt_two_lock;
	wdt_seq_t         seq;
	logic             slow_tick;

	logic [CNT_W-1:0] next_cnt;
	logic [1:0]       next_tsel;
	logic             next_clks;
	logic             next_win_en;
	logic             next_opt_one_lock;
	logic             next_opt_two_lock;
	wdt_seq_t         next_seq;
	logic             next_reset_req;
	logic             next_caused;

	logic [CNT_W:0]   period;
	logic             enabled;
	logic             win_open;
	logic             mode_hold;
	logic             count_en;
	logic             trip;

	wdt_prescale #(.DIV(SLOW_DIVIDE)) i_wdt_prescale (
		.core_clk (core_clk),
		.nrst     (nrst),
		.tick     (slow_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Timeout selection and window

	always_comb begin
		case ({clks, tsel}) // see RQ7, see RQ16
			3'b001:  period = (CNT_W+1)'(BUS_SHORT);
			3'b010:  period = (CNT_W+1)'(BUS_MID);
			3'b011:  period = (CNT_W+1)'(BUS_LONG);
			3'b101:  period = (CNT_W+1)'(SLOW_SHORT);
			3'b110:  period = (CNT_W+1)'(SLOW_MID);
			3'b111:  period = (CNT_W+1)'(SLOW_LONG);
			default: period = (CNT_W+1)'(SLOW_LONG);
		endcase
	end

	assign enabled   = (tsel != TSEL_OFF); // see RQ1
	assign mode_hold = debug_mode | stop_mode;
	assign count_en  = (clks == CLKS_SLOW) ? slow_tick : 1'b1; // see RQ6
	// Window only on bus clock; the 1 kHz source is always open
	assign win_open  = !(clks == CLKS_BUS && win_en) ||
	                   ({1'b0, cnt} >= period - (period >> 2)); // see RQ8, see RQ10

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		next_cnt          = cnt;
		next_tsel         = tsel;
		next_clks         = clks;
		next_win_en       = win_en;
		next_opt_one_lock = opt_one_lock;
		next_opt_two_lock = opt_two_lock;
		next_seq          = seq;
		trip              = 1'b0;
		if (enabled) begin
			if (mode_hold) begin
				if (clks == CLKS_SLOW)
					next_cnt = '0; // see RQ13
			end else if (count_en) begin // see RQ12
				if ({1'b0, cnt} == period - 1'b1)
					trip = 1'b1; // see RQ4
				else
					next_cnt = cnt + 1'b1;
			end
			if (status_wr.valid) begin
				if (status_wr.data != SVC_FIRST && status_wr.data != SVC_SECOND) begin
					trip = 1'b1; // see RQ5
				end else if (!win_open) begin
					trip = 1'b1; // see RQ9
				end else if (status_wr.data == SVC_FIRST) begin
					next_seq = SEQ_ARMED;
				end else if (seq == SEQ_ARMED) begin
					next_cnt = '0; // see RQ2
					next_seq = SEQ_IDLE;
					trip     = 1'b0;
				end
			end
		end
		// Write-once options; first write also re-initialises the counter
		if (opt_one_wr.valid && !opt_one_lock) begin // see RQ11
			next_tsel         = opt_one_wr.data[TSEL_POS +: 2];
			next_opt_one_lock = 1'b1;
			next_cnt          = '0;
		end
		if (opt_two_wr.valid && !opt_two_lock) begin // see RQ11
			next_clks         = opt_two_wr.data[CLKS_POS];
			next_win_en       = opt_two_wr.data[WIN_POS];
			next_opt_two_lock = 1'b1;
			next_cnt          = '0;
		end
		if (trip) begin
			next_cnt = '0;
			next_seq = SEQ_IDLE;
		end
		next_reset_req = trip;
		// Status bit moves only on a trip, never on service writes
		next_caused    = wdt_caused | trip; // see RQ3
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt           <= '0;
			tsel          <= TSEL_RST;
			clks          <= CLKS_RST;
			win_en        <= WIN_RST;
			opt_one_lock  <= 1'b0;
			opt_two_lock  <= 1'b0;
			seq           <= SEQ_IDLE;
			sys_reset_req <= 1'b0;
			wdt_caused    <= 1'b0;
			wdt_enabled   <= 1'b1;
		end else begin
			cnt           <= next_cnt;
			tsel          <= next_tsel;
			clks          <= next_clks;
			win_en        <= next_win_en;
			opt_one_lock  <= next_opt_one_lock;
			opt_two_lock  <= next_opt_two_lock;
			seq           <= next_seq;
			sys_reset_req <= next_reset_req;
			wdt_caused    <= next_caused;
			wdt_enabled   <= (next_tsel != TSEL_OFF);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic quiet;
	assign quiet = !status_wr.valid && !opt_one_wr.valid && !opt_two_wr.valid;

	chk_default_enabled: assert property ( // see RQ1
		!opt_one_lock |-> (tsel == TSEL_RST) && wdt_enabled)
		else $error("watchdog not at default setting before option write");

	chk_default_clock: assert property ( // see RQ7
		!opt_two_lock |-> clks == CLKS_SLOW && win_en == WIN_RST)
		else $error("clock select not at default before option write");

	chk_write_once: assert property ( // see RQ11
		opt_one_lock && opt_two_lock |=> $stable(tsel) && $stable(clks) && $stable(win_en))
		else $error("locked option changed");

	chk_service_restart: assert property ( // see RQ2
		enabled && status_wr.valid && status_wr.data == SVC_SECOND && seq == SEQ_ARMED && win_open
		|=> cnt == '0 && !sys_reset_req)
		else $error("service pair did not restart counter");

	chk_status_kept: assert property ( // see RQ3
		$rose(wdt_caused) |-> sys_reset_req)
		else $error("status changed without watchdog reset");

	chk_timeout_trip: assert property ( // see RQ4
		enabled && !mode_hold && count_en && {1'b0, cnt} == period - 1'b1 && quiet
		|=> sys_reset_req ##1 !sys_reset_req)
		else $error("timeout did not reset");

	chk_bad_byte: assert property ( // see RQ5
		enabled && status_wr.valid && status_wr.data != SVC_FIRST && status_wr.data != SVC_SECOND
		|=> sys_reset_req && cnt == '0)
		else $error("bad service byte did not reset");

	chk_early_write: assert property ( // see RQ9
		enabled && clks == CLKS_BUS && win_en && status_wr.valid && {1'b0, cnt} < period - (period >> 2)
		|=> sys_reset_req)
		else $error("premature service write did not reset");

	// Any service byte on the slow source must pass, except at a true expiry
	chk_slow_nowin: assert property ( // see RQ10
		enabled && clks == CLKS_SLOW && status_wr.valid &&
		(status_wr.data == SVC_FIRST || status_wr.data == SVC_SECOND) &&
		!(count_en && !mode_hold && {1'b0, cnt} == period - 1'b1)
		|=> !sys_reset_req)
		else $error("window active on 1 kHz source");

	chk_bus_hold: assert property ( // see RQ12
		enabled && clks == CLKS_BUS && mode_hold && quiet |=> $stable(cnt))
		else $error("bus-clock counter moved in debug or stop");

	chk_slow_clear: assert property ( // see RQ13
		enabled && clks == CLKS_SLOW && mode_hold |=> cnt == '0)
		else $error("1 kHz counter not cleared in debug or stop");

	chk_slow_rate: assert property ( // see RQ6
		clks == CLKS_SLOW && !slow_tick && !mode_hold && quiet |=> $stable(cnt))
		else $error("counter advanced without 1 kHz tick");
endmodule

//--- dv/wdt_top_tb.sv
`timescale 1ns/10ps
module wdt_top_tb import wdt_pkg::*;;
	localparam int DIV   = 4;
	localparam int LP[4] = '{0, 8, 16, 32};
	localparam int BP[4] = '{0, 16, 32, 64};

	logic       core_clk   = 1'b0;
	logic       nrst       = 1'b0;
	wdt_wr_t    status_wr  = '0;
	wdt_wr_t    opt_one_wr = '0;
	wdt_wr_t    opt_two_wr = '0;
	logic       debug_mode = 1'b0;
	logic       stop_mode  = 1'b0;
	logic       sys_reset_req;
	logic       wdt_caused;
	logic       wdt_enabled;
	int         n_fail      = 0;
	int         check_count = 0;
	int         seed        = 32'hbed0;
	int         p;
	logic [7:0] bad;
	string      cur         = "";

	always #25 core_clk = ~core_clk;

	wdt_top #(
		.SLOW_DIVIDE(DIV), .SLOW_SHORT(LP[1]), .SLOW_MID(LP[2]), .SLOW_LONG(LP[3]),
		.BUS_SHORT(BP[1]), .BUS_MID(BP[2]), .BUS_LONG(BP[3])
	) i_wdt_top (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.status_wr    (status_wr),
		.opt_one_wr   (opt_one_wr),
		.opt_two_wr   (opt_two_wr),
		.debug_mode   (debug_mode),
		.stop_mode    (stop_mode),
		.sys_reset_req(sys_reset_req),
		.wdt_caused   (wdt_caused),
		.wdt_enabled  (wdt_enabled)
	);

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("test %s ends", cur);
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Options are write-once, so every scenario starts from a fresh reset
	task automatic rst(input string name);
		if (cur != "") begin
			$display("test %s ends", cur);
		end
		cur = name;
		@(negedge core_clk);
		nrst = 1'b0;
		repeat (6) @(negedge core_clk);
		chk(wdt_enabled, 1);
		chk(wdt_caused, 0);
		nrst = 1'b1;
	endtask

	task automatic sw(input logic [7:0] d);
		@(negedge core_clk);
		status_wr = '{1'b1, d};
		@(negedge core_clk);
		status_wr = '0;
	endtask

	task automatic op(input logic [7:0] a, input logic [7:0] b);
		@(negedge core_clk);
		opt_one_wr = '{1'b1, a};
		@(negedge core_clk);
		opt_one_wr = '0;
		opt_two_wr = '{1'b1, b};
		@(negedge core_clk);
		opt_two_wr = '0;
	endtask

	task automatic quiet(input int n);
		logic seen_req;
		seen_req = 1'b0;
		repeat (n) begin
			@(negedge core_clk);
			seen_req |= sys_reset_req;
		end
		chk(seen_req, 0);
	endtask

	// Cycle counts are taken from the falling edge at which the task is called
	task automatic wait_req(input int lo, input int hi);
		int n;
		n = 0;
		while (sys_reset_req !== 1'b1 && n <= hi) begin
			@(negedge core_clk);
			n++;
		end
		if (n > hi) begin
			n_fail++;
			$display("wrong value at %0t: no reset request", $time);
			results();
		end else begin
			chk(n >= lo, 1);
			@(negedge core_clk);
			chk(sys_reset_req, 0);
			chk(wdt_caused, 1);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		for (int c = 0; c < 2; c++) begin
			for (int t = 1; t < 4; t++) begin
				rst("timeout select");
				op({t[1:0], 6'h00}, {c[0], 7'h00});
				// The 1 kHz tick phase is free-running, hence the slack
				p = c ? LP[t] * DIV : BP[t];
				wait_req(p - 6 * c, p + 6 * c);
			end
		end
		rst("default");
		wait_req(LP[3] * DIV - 8, LP[3] * DIV + 8);
		rst("write once");
		op(8'h40, 8'h00);
		op(8'h00, 8'h80);
		chk(wdt_enabled, 1);
		wait_req(13, 13);
		rst("service");
		op(8'h40, 8'h00);
		// Service comes from the main sequence only, never from a side process
		repeat (5) begin
			quiet(6);
			sw(8'h55);
			sw(8'haa);
		end
		sw(8'haa);
		wait_req(13, 15);
		rst("bad byte");
		op(8'hc0, 8'h00);
		repeat (4) begin
			bad = 8'($random(seed));
			if (bad == 8'h55 || bad == 8'haa) begin
				bad ^= 8'h01;
			end
			sw(bad);
			wait_req(0, 1);
		end
		rst("window early");
		op(8'h40, 8'h40);
		quiet(2);
		sw(8'h55);
		wait_req(0, 1);
		rst("window late");
		op(8'h40, 8'h40);
		quiet(11);
		sw(8'h55);
		sw(8'haa);
		quiet(10);
		wait_req(4, 8);
		rst("debug hold");
		op(8'h40, 8'h00);
		quiet(8);
		debug_mode = 1'b1;
		quiet(20);
		debug_mode = 1'b0;
		wait_req(6, 9);
		rst("slow clock stop");
		op(8'hc0, 8'hc0);
		sw(8'h55);
		sw(8'haa);
		quiet(100);
		stop_mode = 1'b1;
		quiet(40);
		stop_mode = 1'b0;
		quiet(100);
		wait_req(18, 42);
		rst("disabled");
		op(8'h00, 8'h00);
		chk(wdt_enabled, 0);
		sw(8'h13);
		quiet(150);
		results();
	end
endmodule
